// ---- verification/fssr_fuse_model.sv ----
// Fuse checksum engine model that answers each check start after a delay
`timescale 1ns/10ps
module fssr_fuse_model #(
    parameter [7:0] DELAY = 8'h03
) (
    input  wire clock,
    input  wire reset,
    input  wire start,
    input  wire corrupt,
    output reg  done,
    output reg  crc_ok
);
    reg [7:0] count;
    // Verdict after delay; verdict line toggles when not valid
    always @(posedge clock) begin
        done   <= !reset && count == 8'h01;
        crc_ok <= reset ? 1'b0 : count == 8'h01 ? !corrupt : !crc_ok;
        count  <= reset ? 8'h00 : start ? DELAY : count - {7'h00, count != 8'h00};
    end
endmodule // fssr_fuse_model

// ---- verification/fssr_regs_properties.sv ----
// Port assertions for the fail-safe status register bank
`timescale 1ns/10ps
module fssr_regs_check #(
    parameter FUSE_CHECK_CYCLES = 50,
    parameter PULSE_CYCLES      = 16
) (
    input wire        clock,
    input wire        reset,
    input wire        reg_write,
    input wire        reg_read,
    input wire [7:0]  reg_addr,
    input wire [23:0] reg_wdata,
    input wire [23:0] reg_rdata,
    input wire        reg_rvalid,
    input wire        reset_out_pin_n,
    input wire [1:0]  aux_monitor_event,
    input wire [1:0]  io_supply_event,
    input wire [1:0]  core_supply_event,
    input wire [5:0]  monitor_flag_set,
    input wire        monitor_irq_request,
    input wire        debug_leave_cmd,
    input wire        fuse_check_start
);
    reg  [2:0]  inhibit;
    reg  [7:0]  low_count;
    reg  [31:0] gap;
    reg         seen;
    wire [5:0]  events   = {aux_monitor_event, io_supply_event, core_supply_event};
    wire        unmasked = |(events & ~{{2{inhibit[2]}}, {2{inhibit[1]}}, {2{inhibit[0]}}});
    wire        leave_wr = reg_write && reg_addr == 8'h0c && reg_wdata[22];
    wire        inh_wr   = reg_write && reg_addr == 8'h0b;
    // Inhibit mirror, low pulse length and spacing of fuse check starts
    always @(posedge clock) inhibit <= reset ? 3'h0 : inh_wr ? reg_wdata[14:12] : inhibit;
    always @(posedge clock) low_count <= (reset || reset_out_pin_n) ? 8'h00 : low_count + 8'h01;
    always @(posedge clock) gap <= (reset || fuse_check_start) ? 32'h0 : gap + 32'h1;
    always @(posedge clock) seen <= !reset && (seen || fuse_check_start);
    ////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Each output tied to its cause
    a_read_answer: assert property (reg_read |=> reg_rvalid && reg_rdata[7:0] == 8'h00)
        else $error("read not answered");
    a_idle_read: assert property (!$past(reg_read) |-> !reg_rvalid && reg_rdata == 24'h0)
        else $error("read data outside answer");
    a_pulse_start: assert property (
        reg_write && reg_addr == 8'h09 && reg_wdata[15] && reset_out_pin_n |-> ##2 !reset_out_pin_n)
        else $error("reset pin not driven");
    a_pulse_length: assert property ($rose(reset_out_pin_n) |-> low_count == PULSE_CYCLES)
        else $error("reset pulse length wrong");
    a_monitor_copy: assert property (1'b1 |=> monitor_flag_set == $past(events))
        else $error("monitor flags not recorded");
    a_irq_inhibit: assert property (1'b1 |=> monitor_irq_request == $past(unmasked))
        else $error("interrupt inhibit wrong");
    a_debug_leave: assert property (1'b1 |=> debug_leave_cmd == $past(leave_wr))
        else $error("debug leave pulse wrong");
    a_fuse_period: assert property (fuse_check_start && seen |-> gap == FUSE_CHECK_CYCLES - 1)
        else $error("fuse check spacing wrong");
endmodule // fssr_regs_check

bind fssr_regs fssr_regs_check #(
    .FUSE_CHECK_CYCLES(FUSE_CHECK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)
) u_fssr_regs_check (
    .clock(clock), .reset(reset), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reset_out_pin_n(reset_out_pin_n),
    .aux_monitor_event(aux_monitor_event), .io_supply_event(io_supply_event),
    .core_supply_event(core_supply_event), .monitor_flag_set(monitor_flag_set),
    .monitor_irq_request(monitor_irq_request), .debug_leave_cmd(debug_leave_cmd), .fuse_check_start(fuse_check_start)
);

// ---- verification/fssr_regs_tb.sv ----
// Self-checking bench for the fail-safe status register bank
`timescale 1ns/10ps
module fssr_regs_tb;
    localparam FUSE  = 50;
    localparam PULSE = 4;
    // Reset reads of 0x09 to 0x0c, then flag rows of address, idle value and flag bit
    localparam [95:0]  RST  = {24'h000600, 24'h000000, 24'h008100, 24'h020000};
    localparam [279:0] ROWS = {8'h0c, 24'h000600, 24'h020000, 8'h0a, 24'h008100, 24'h000200,
        8'h0a, 24'h008100, 24'h000400, 8'h09, 24'h0, 24'h010000, 8'h09, 24'h0, 24'h020000};
    reg         clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    reg         normal_mode = 1'b0, init_only_write = 1'b0, debug_active_status = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [23:0] reg_wdata = 24'h0;
    reg  [5:0]  ev = 6'h00, mon = 6'h00;
    reg  [4:0]  code = 5'h06;
    reg  [31:0] seed = 32'h0000ec3e; // Seed 60478
    reg  [55:0] row;
    wire [23:0] reg_rdata;
    wire [5:0]  monitor_flag_set;
    wire        reg_rvalid, reset_out_pin_n, monitor_irq_request, fuse_check_start, fuse_check_done, fuse_crc_ok;
    integer     miscompares = 0, samples_checked = 0, i, n;
    ////////////////////////////////////////
    // Clock and the two instances
    always #4 clock = ~clock;
    fssr_regs #(.FUSE_CHECK_CYCLES(FUSE), .PULSE_CYCLES(PULSE)) u_fssr_regs (
        .clock(clock), .reset(reset), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .normal_mode(normal_mode), .init_only_write(init_only_write),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reset_pin_seen(ev[0]), .reset_pin_short(ev[1]),
        .reset_out_pin_n(reset_out_pin_n), .bus_crc_bad(ev[2]), .bus_access_bad(ev[3]),
        .aux_monitor_event(mon[5:4]), .io_supply_event(mon[3:2]), .core_supply_event(mon[1:0]),
        .monitor_flag_set(monitor_flag_set), .monitor_irq_request(monitor_irq_request),
        .debug_active_status(debug_active_status), .debug_leave_cmd(), .fuse_check_start(fuse_check_start),
        .fuse_check_done(fuse_check_done), .fuse_crc_ok(fuse_crc_ok), .safety_machine_code(code),
        .init_reg_value(ev[4] ? 16'h5a3c : 16'ha5c3), .init_reg_shadow(16'h5a3c));
    fssr_fuse_model #(.DELAY(8'h03)) u_fssr_fuse_model (.clock(clock), .reset(reset),
        .start(fuse_check_start), .corrupt(ev[5]), .done(fuse_check_done), .crc_ok(fuse_crc_ok));
    ////////////////////////////////////////
    // Random source and expected interrupt
    function [31:0] xorshift(input [31:0] s);
        begin
            s = s ^ (s << 13);
            s = s ^ (s >> 17);
            xorshift = s ^ (s << 5);
        end
    endfunction
    function irq_of(input [5:0] m, input [2:0] k);
        irq_of = |(m & ~{k[2], k[2], k[1], k[1], k[0], k[0]});
    endfunction
    // Compare, register access and closing report
    task chk(input [23:0] got, input [23:0] want);
        begin
            samples_checked = samples_checked + 1;
            if (got !== want) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, want);
            end
        end
    endtask
    task xfer(input w, input [7:0] a, input [23:0] d);
        begin
            {reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, a, d};
            @(negedge clock);
            {reg_write, reg_read} = 2'b00;
            if (!w) chk(reg_rdata, d);
            @(negedge clock);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(negedge clock);
        reset = 1'b0;
        for (i = 0; i < 4; i = i + 1) xfer(0, 8'h09 + i, RST[i*24 +: 24]);
        xfer(1, 8'h09, 24'h020000);
        xfer(0, 8'h09, 24'h000000);
        chk(reset_out_pin_n, 24'h1);
        // Sticky flags set by one-cycle causes, cleared by writing one
        for (i = 0; i < 5; i = i + 1) begin
            row = ROWS[i*56 +: 56];
            ev[i] = 1'b1;
            @(negedge clock);
            ev[i] = 1'b0;
            xfer(0, row[55:48], row[47:24] | row[23:0]);
            xfer(1, row[55:48], row[23:0]);
            xfer(0, row[55:48], row[47:24]);
        end
        // Unmapped read, then init-only write in normal mode
        xfer(0, 8'h20, 24'h0);
        xfer(0, 8'h0a, 24'h008300);
        xfer(1, 8'h0a, 24'h000200);
        {normal_mode, init_only_write} = 2'b11;
        xfer(1, 8'h0b, 24'h0);
        init_only_write = 1'b0;
        xfer(0, 8'h0a, 24'h008300);
        xfer(1, 8'h0a, 24'h000200);
        // Reset pin pulse counted in a fixed window that opens as the write returns
        xfer(1, 8'h09, 24'h008000);
        n = 0;
        repeat (20) begin
            n = n + (reset_out_pin_n === 1'b0);
            @(negedge clock);
        end
        chk(n, PULSE);
        xfer(0, 8'h09, 24'h020000);
        // Fuse corruption over two check periods
        ev[5] = 1'b1;
        repeat (2 * FUSE) @(negedge clock);
        ev[5] = 1'b0;
        xfer(0, 8'h0c, 24'h080600);
        xfer(1, 8'h0c, 24'h080000);
        xfer(0, 8'h0c, 24'h000600);
        // Random inhibit masks, monitor events, state codes and debug level
        for (i = 0; i < 20; i = i + 1) begin
            seed = xorshift(seed);
            xfer(1, 8'h0b, {9'h0, seed[14:12], 12'h0});
            xfer(0, 8'h0b, {9'h0, seed[14:12], 12'h0});
            {debug_active_status, code, mon} = {seed[21:16], seed[5:0]};
            @(negedge clock);
            mon = 6'h00;
            chk(monitor_flag_set, seed[5:0]);
            chk(monitor_irq_request, irq_of(seed[5:0], seed[14:12]));
            xfer(0, 8'h0c, {2'h0, seed[21], 8'h0, seed[20:16], 8'h0});
            if (seed[22]) xfer(1, 8'h0c, 24'h400000);
        end
        summarize;
    end
endmodule // fssr_regs_tb

// ---- verilog/fssr_map.vh ----
// Register map, field positions, reset values and timing constants of the fail-safe status bank
`ifndef FSSR_MAP_VH
`define FSSR_MAP_VH

// Register addresses on the decoded fail-safe access port
`define FSSR_ADDR_SAFETY_PIN_FLAGS   8'h09
`define FSSR_ADDR_FAULT_FLAGS        8'h0a
`define FSSR_ADDR_IRQ_INHIBIT        8'h0b
`define FSSR_ADDR_MACHINE_STATUS     8'h0c

// Safety pin flags fields
`define FSSR_BIT_RESET_OCCURRED      17
`define FSSR_BIT_RESET_SHORT         16
`define FSSR_BIT_RESET_REQUEST       15

// Fault flags fields
`define FSSR_BIT_BUS_CRC             10
`define FSSR_BIT_BUS_VIOLATION       9
`define FSSR_BIT_FAULT_RSVD_HI       15
`define FSSR_BIT_FAULT_RSVD_LO       8

// Interrupt inhibit fields
`define FSSR_BIT_INH_AUX             14
`define FSSR_BIT_INH_IO              13
`define FSSR_BIT_INH_CORE            12

// Machine status fields
`define FSSR_BIT_DEBUG_LEAVE         22
`define FSSR_BIT_DEBUG_ACTIVE        21
`define FSSR_BIT_FUSE_CRC            19
`define FSSR_BIT_SHADOW_MISMATCH     17
`define FSSR_BIT_STATE_HI            12
`define FSSR_BIT_STATE_LO            8

// Reset values
`define FSSR_RST_RESET_OCCURRED      1'b1
`define FSSR_RST_RESERVED_ONE        1'b1
`define FSSR_RST_STATE_CODE          5'h06

// Timing: fuse check period and reset pin pulse length
`define FSSR_CLOCK_MHZ               125
`define FSSR_FUSE_CHECK_MS           5
`define FSSR_FUSE_CHECK_CYCLES       (`FSSR_FUSE_CHECK_MS * 1000 * `FSSR_CLOCK_MHZ)
`define FSSR_RESET_PULSE_CYCLES      16

`endif

// ---- verilog/fssr_pulse_gen.v ----
// Reset pin pulse generator: one fixed-length low pulse per start
`timescale 1ns/10ps
`include "fssr_map.vh"
module fssr_pulse_gen #(
    parameter LENGTH = `FSSR_RESET_PULSE_CYCLES,
    parameter WIDTH  = 8
) (
    input  wire             clock,
    input  wire             reset,
    input  wire             start,
    output reg              busy,
    output wire             done
);
    reg  [WIDTH-1:0] count;

    // Counts the pulse down; a start while busy is ignored
    always @(posedge clock) begin
        if (reset) begin
            busy  <= 1'b0;
            count <= {WIDTH{1'b0}};
        end else if (!busy && start) begin
            busy  <= 1'b1;
            count <= LENGTH[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
        end else if (busy) begin
            if (count == {WIDTH{1'b0}}) begin
                busy <= 1'b0;
            end else begin
                count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    assign done = busy && (count == {WIDTH{1'b0}});
endmodule // fssr_pulse_gen

// ---- verilog/fssr_regs.v ----
// Fail-safe status register bank: reset pin, bus errors, monitor inhibit, debug and corruption status
//
// Function
// - Any reset pin assertion sets the reset-occurred flag, bit 17; write 1 clears.
// - Reset pin found shorted high sets sticky flag bit 16; write 1 clears.
// - Writing 1 to bit 15 pulses the reset pin; writing 0 does nothing.
// - Bad checksum on a fail-safe bus transfer sets flag bit 10; write 1 clears.
// - Bad access, wrong address or init-only write in normal mode sets flag bit 9; write 1 clears.
// - Inhibit bit 14 set suppresses auxiliary monitor overvoltage/undervoltage interrupts.
// - Inhibit bit 13 set suppresses I/O supply monitor overvoltage/undervoltage interrupts.
// - Inhibit bit 12 set suppresses core supply monitor overvoltage/undervoltage interrupts.
// - Bit 21 shows debug mode live; writing 1 to bit 22 leaves debug mode.
// - Fuse configuration checked every 5 ms; mismatch sets sticky flag bit 19.
// - Init registers compared with inverted shadows; mismatch sets flag bit 17.
// - Bits 12 to 8 show the safety machine state; reset code 0 0110.
`timescale 1ns/10ps
`include "fssr_map.vh"
module fssr_regs #(
    parameter FUSE_CHECK_CYCLES = `FSSR_FUSE_CHECK_CYCLES,
    parameter PULSE_CYCLES      = `FSSR_RESET_PULSE_CYCLES,
    parameter INIT_WIDTH        = 16
) (
    input  wire                  clock,
    input  wire                  reset,
    input  wire                  reg_write,
    input  wire                  reg_read,
    input  wire [7:0]            reg_addr,
    input  wire [23:0]           reg_wdata,
    input  wire                  normal_mode,
    input  wire                  init_only_write,
    output reg  [23:0]           reg_rdata,
    output reg                   reg_rvalid,
    input  wire                  reset_pin_seen,
    input  wire                  reset_pin_short,
    output wire                  reset_out_pin_n,
    input  wire                  bus_crc_bad,
    input  wire                  bus_access_bad,
    input  wire [1:0]            aux_monitor_event,
    input  wire [1:0]            io_supply_event,
    input  wire [1:0]            core_supply_event,
    output reg  [5:0]            monitor_flag_set,
    output reg                   monitor_irq_request,
    input  wire                  debug_active_status,
    output reg                   debug_leave_cmd,
    output reg                   fuse_check_start,
    input  wire                  fuse_check_done,
    input  wire                  fuse_crc_ok,
    input  wire [INIT_WIDTH-1:0] init_reg_value,
    input  wire [INIT_WIDTH-1:0] init_reg_shadow,
    input  wire [4:0]            safety_machine_code
);
    ////////////////////////////////////////////////////////////////////////////////
    // Decode and status storage
    reg                  reset_occurred_flag;
    reg                  reset_pin_short_flag;
    reg                  reset_pulse_request;
    reg                  bus_checksum_error;
    reg                  bus_access_violation;
    reg                  aux_monitor_irq_inhibit;
    reg                  io_supply_irq_inhibit;
    reg                  core_supply_irq_inhibit;
    reg                  fuse_config_crc_error;
    reg                  shadow_mismatch_error;
    reg  [4:0]           machine_code;
    reg  [31:0]          fuse_timer;
    wire                 pulse_busy;
    wire                 pulse_done;
    wire                 pulse_start;
    wire                 known_addr;
    wire                 shadow_bad;
    wire [5:0]           monitor_events;
    wire [5:0]           monitor_mask;

    // True when the address names the given register of this bank
    function is_addr;
        input [7:0] a;
        input [7:0] target;
        begin
            is_addr = (a == target);
        end
    endfunction

    // One-cycle write-1 strobe for a field of a given register
    function wone;
        input [7:0]  a;
        input [7:0]  target;
        input        wr;
        input [23:0] data;
        input [4:0]  pos;
        begin
            wone = wr && (a == target) && data[pos];
        end
    endfunction

    assign known_addr = is_addr(reg_addr, `FSSR_ADDR_SAFETY_PIN_FLAGS)
                     || is_addr(reg_addr, `FSSR_ADDR_FAULT_FLAGS)
                     || is_addr(reg_addr, `FSSR_ADDR_IRQ_INHIBIT)
                     || is_addr(reg_addr, `FSSR_ADDR_MACHINE_STATUS);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset pin request and pulse
    // Pulse on write one
    assign pulse_start = wone(reg_addr, `FSSR_ADDR_SAFETY_PIN_FLAGS, reg_write, reg_wdata,
                              `FSSR_BIT_RESET_REQUEST);

    fssr_pulse_gen #(
        .LENGTH (PULSE_CYCLES),
        .WIDTH  (8)
    ) u_pulse (
        .clock (clock),
        .reset (reset),
        .start (reset_pulse_request),
        .busy  (pulse_busy),
        .done  (pulse_done)
    );

    assign reset_out_pin_n = ~pulse_busy;

    // Request is held until the pulse ends
    always @(posedge clock) begin
        if (reset) begin
            reset_pulse_request <= 1'b0;
        end else if (pulse_start) begin
            reset_pulse_request <= 1'b1;
        end else if (pulse_done) begin
            reset_pulse_request <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky flags: a set in the same cycle as a clear wins
    always @(posedge clock) begin
        if (reset) begin
            reset_occurred_flag   <= `FSSR_RST_RESET_OCCURRED;
            reset_pin_short_flag  <= 1'b0;
            bus_checksum_error    <= 1'b0;
            bus_access_violation  <= 1'b0;
            fuse_config_crc_error <= 1'b0;
            shadow_mismatch_error <= 1'b0;
        end else begin
            reset_occurred_flag <= (reset_pin_seen || (pulse_busy && pulse_done))
                || (reset_occurred_flag && !wone(reg_addr, `FSSR_ADDR_SAFETY_PIN_FLAGS, reg_write,
                                                 reg_wdata, `FSSR_BIT_RESET_OCCURRED));
            reset_pin_short_flag <= reset_pin_short
                || (reset_pin_short_flag && !wone(reg_addr, `FSSR_ADDR_SAFETY_PIN_FLAGS, reg_write,
                                                  reg_wdata, `FSSR_BIT_RESET_SHORT));
            bus_checksum_error <= bus_crc_bad
                || (bus_checksum_error && !wone(reg_addr, `FSSR_ADDR_FAULT_FLAGS, reg_write,
                                                reg_wdata, `FSSR_BIT_BUS_CRC));
            bus_access_violation <= bus_access_bad
                || ((reg_write || reg_read) && !known_addr)
                || (reg_write && init_only_write && normal_mode)
                || (bus_access_violation && !wone(reg_addr, `FSSR_ADDR_FAULT_FLAGS, reg_write,
                                                  reg_wdata, `FSSR_BIT_BUS_VIOLATION));
            fuse_config_crc_error <= (fuse_check_done && !fuse_crc_ok)
                || (fuse_config_crc_error && !wone(reg_addr, `FSSR_ADDR_MACHINE_STATUS, reg_write,
                                                   reg_wdata, `FSSR_BIT_FUSE_CRC));
            shadow_mismatch_error <= shadow_bad
                || (shadow_mismatch_error && !wone(reg_addr, `FSSR_ADDR_MACHINE_STATUS, reg_write,
                                                   reg_wdata, `FSSR_BIT_SHADOW_MISMATCH));
        end
    end

    assign shadow_bad = (init_reg_value != ~init_reg_shadow);

    ////////////////////////////////////////////////////////////////////////////////
    // Fuse check timer
    // Five millisecond cycle
    always @(posedge clock) begin
        if (reset) begin
            fuse_timer       <= 32'h0000_0000;
            fuse_check_start <= 1'b0;
        end else if (fuse_timer == FUSE_CHECK_CYCLES[31:0] - 32'h0000_0001) begin
            fuse_timer       <= 32'h0000_0000;
            fuse_check_start <= 1'b1;
        end else begin
            fuse_timer       <= fuse_timer + 32'h0000_0001;
            fuse_check_start <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt inhibit register and monitor gating
    always @(posedge clock) begin
        if (reset) begin
            aux_monitor_irq_inhibit <= 1'b0;
            io_supply_irq_inhibit   <= 1'b0;
            core_supply_irq_inhibit <= 1'b0;
        end else if (reg_write && is_addr(reg_addr, `FSSR_ADDR_IRQ_INHIBIT)) begin
            aux_monitor_irq_inhibit <= reg_wdata[`FSSR_BIT_INH_AUX];
            io_supply_irq_inhibit   <= reg_wdata[`FSSR_BIT_INH_IO];
            core_supply_irq_inhibit <= reg_wdata[`FSSR_BIT_INH_CORE];
        end
    end

    assign monitor_events = {aux_monitor_event, io_supply_event, core_supply_event};
    // Auxiliary inhibit, I/O inhibit, core inhibit
    assign monitor_mask   = {{2{aux_monitor_irq_inhibit}}, {2{io_supply_irq_inhibit}},
                             {2{core_supply_irq_inhibit}}};

    // Interrupt request and flag set strobes
    always @(posedge clock) begin
        if (reset) begin
            monitor_irq_request <= 1'b0;
            monitor_flag_set    <= 6'h00;
        end else begin
            monitor_irq_request <= |(monitor_events & ~monitor_mask);
            monitor_flag_set    <= monitor_events;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Debug leave command and state code
    always @(posedge clock) begin
        if (reset) begin
            debug_leave_cmd <= 1'b0;
            machine_code    <= `FSSR_RST_STATE_CODE;
        end else begin
            debug_leave_cmd <= wone(reg_addr, `FSSR_ADDR_MACHINE_STATUS, reg_write, reg_wdata,
                                    `FSSR_BIT_DEBUG_LEAVE);
            machine_code    <= safety_machine_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path, registered one cycle after the read strobe
    always @(posedge clock) begin
        if (reset) begin
            reg_rdata  <= 24'h000000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            reg_rdata  <= 24'h000000;
            if (reg_read) begin
                case (reg_addr)
                    `FSSR_ADDR_SAFETY_PIN_FLAGS: begin
                        reg_rdata[`FSSR_BIT_RESET_OCCURRED] <= reset_occurred_flag;
                        reg_rdata[`FSSR_BIT_RESET_SHORT]    <= reset_pin_short_flag;
                    end
                    `FSSR_ADDR_FAULT_FLAGS: begin
                        reg_rdata[`FSSR_BIT_FAULT_RSVD_HI]  <= `FSSR_RST_RESERVED_ONE;
                        reg_rdata[`FSSR_BIT_FAULT_RSVD_LO]  <= `FSSR_RST_RESERVED_ONE;
                        reg_rdata[`FSSR_BIT_BUS_CRC]        <= bus_checksum_error;
                        reg_rdata[`FSSR_BIT_BUS_VIOLATION]  <= bus_access_violation;
                    end
                    `FSSR_ADDR_IRQ_INHIBIT: begin
                        reg_rdata[`FSSR_BIT_INH_AUX]        <= aux_monitor_irq_inhibit;
                        reg_rdata[`FSSR_BIT_INH_IO]         <= io_supply_irq_inhibit;
                        reg_rdata[`FSSR_BIT_INH_CORE]       <= core_supply_irq_inhibit;
                    end
                    `FSSR_ADDR_MACHINE_STATUS: begin
                        reg_rdata[`FSSR_BIT_DEBUG_ACTIVE]   <= debug_active_status;
                        reg_rdata[`FSSR_BIT_FUSE_CRC]       <= fuse_config_crc_error;
                        reg_rdata[`FSSR_BIT_SHADOW_MISMATCH] <= shadow_mismatch_error;
                        reg_rdata[`FSSR_BIT_STATE_HI:`FSSR_BIT_STATE_LO] <= machine_code;
                    end
                    default: begin
                        reg_rdata <= 24'h000000;
                    end
                endcase
            end
        end
    end
endmodule // fssr_regs
